/* File: logic/retentive_up_down_counter.sv */
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Rising up rung adds one
// - Rising down rung subtracts one
// - Up past top wraps, sets high flag
// - Down past bottom wraps, sets low flag
// - Done while count at or above preset
// - Up enable flag mirrors up rung
// - Down enable flag mirrors down rung
// - Flags and count kept between scans
// - Clear with false rung changes nothing
// - Counter clear zeroes count and flags
// - Clear also serves timer and control elements
// - Element is status, preset, count words
// - Count and preset are signed sixteen bit
// - Counting continues beyond the preset
module retentive_up_down_counter
(
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctr_pkg::ADDR_W-1:0] paddr,
  input wire logic [ctr_pkg::DATA_W-1:0] pwdata,
  output logic [ctr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Status
  output logic done_out
);
  import ctr_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic {ap_idle, ap_ack} apb_st_e;

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  counter_link_if link ();

  apb_st_e st_r, st_nxt;
  logic [DATA_W-1:0] prdata_r;
  logic pready_r, pslverr_r, done_out_r;
  logic [WORD_W-1:0] preset_r;
  logic [WORD_W-1:0] tmr_word0_r, tmr_acc_r;
  logic [WORD_W-1:0] ctl_word0_r, ctl_pos_r;
  logic [WORD_W-1:0] scan_cnt_r;
  logic [CMD_W-1:0] cmd_r;
  logic scan_r;

  // ****************************************
  // Address decode
  // ****************************************
  logic hit_ctr0, hit_preset, hit_acc, hit_scan, hit_tmr0, hit_tacc, hit_ctl0, hit_pos, hit_cnt;
  logic mapped, access_en, finish, take_write;
  logic [WORD_W-1:0] rd_word;
  logic [1:0] target;
  logic clr_go, clr_tmr, clr_ctl;
  logic [WORD_W-1:0] tmr_word0_nxt, tmr_acc_nxt, ctl_word0_nxt, ctl_pos_nxt, preset_nxt;

  assign hit_ctr0 = is_reg(paddr, OFF_CTR_WORD0);
  assign hit_preset = is_reg(paddr, OFF_CTR_PRESET);
  assign hit_acc = is_reg(paddr, OFF_CTR_ACC);
  assign hit_scan = is_reg(paddr, OFF_SCAN_CMD);
  assign hit_tmr0 = is_reg(paddr, OFF_TMR_WORD0);
  assign hit_tacc = is_reg(paddr, OFF_TMR_ACC);
  assign hit_ctl0 = is_reg(paddr, OFF_CTL_WORD0);
  assign hit_pos = is_reg(paddr, OFF_CTL_POS);
  assign hit_cnt = is_reg(paddr, OFF_SCAN_CNT);
  assign mapped = |{hit_ctr0, hit_preset, hit_acc, hit_scan, hit_tmr0, hit_tacc, hit_ctl0,
                    hit_pos, hit_cnt};

  // ****************************************
  // Read selection
  // ****************************************
  assign rd_word = hit_ctr0 ? link.word0 :
                   hit_preset ? preset_r :
                   hit_acc ? link.acc :
                   hit_scan ? {10'h000, cmd_r} :
                   hit_tmr0 ? tmr_word0_r :
                   hit_tacc ? tmr_acc_r :
                   hit_ctl0 ? ctl_word0_r :
                   hit_pos ? ctl_pos_r :
                   hit_cnt ? scan_cnt_r : WORD_RESET;

  // ****************************************
  // APB handshake
  // ****************************************
  assign access_en = psel && penable;
  assign finish = access_en && pready_r && (st_r == ap_ack);
  assign take_write = finish && pwrite && mapped;
  assign st_nxt = (st_r == ap_idle && access_en) ? ap_ack : ap_idle;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= ap_idle;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      pready_r <= (st_nxt == ap_ack);
      pslverr_r <= (st_nxt == ap_ack) && !mapped;
      prdata_r <= (st_nxt == ap_ack && !pwrite) ? {16'h0000, rd_word} : '0;
    end
  end

  // ****************************************
  // Scan command and clear steering
  // ****************************************
  assign target = cmd_r[TGT_LSB +: 2];
  assign clr_go = scan_r && cmd_r[BIT_SCAN_CLR];
  assign clr_tmr = clr_go && (target == TGT_TIMER);
  assign clr_ctl = clr_go && (target == TGT_CONTROL);

  assign link.scan = scan_r;
  assign link.up_rung = cmd_r[BIT_SCAN_UP];
  assign link.dn_rung = cmd_r[BIT_SCAN_DN];
  assign link.clr = cmd_r[BIT_SCAN_CLR] && (target == TGT_COUNTER);
  assign link.preset = preset_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scan_r <= 1'b0;
      cmd_r <= '0;
      scan_cnt_r <= WORD_RESET;
    end
    else if (ce)
    begin
      scan_r <= take_write && hit_scan;
      if (take_write && hit_scan)
        cmd_r <= pwdata[CMD_W-1:0];
      if (scan_r)
        scan_cnt_r <= scan_cnt_r + 16'h0001;
    end
  end

  // ****************************************
  // Preset, timer and control elements
  // ****************************************
  assign preset_nxt = (take_write && hit_preset) ? pwdata[WORD_W-1:0] : preset_r;
  assign tmr_word0_nxt = clr_tmr ? (tmr_word0_r & ~TMR_CLEAR_MASK) :
                         (take_write && hit_tmr0) ? pwdata[WORD_W-1:0] : tmr_word0_r;
  assign tmr_acc_nxt = clr_tmr ? WORD_RESET :
                       (take_write && hit_tacc) ? pwdata[WORD_W-1:0] : tmr_acc_r;
  assign ctl_word0_nxt = clr_ctl ? (ctl_word0_r & ~CTL_CLEAR_MASK) :
                         (take_write && hit_ctl0) ? pwdata[WORD_W-1:0] : ctl_word0_r;
  assign ctl_pos_nxt = clr_ctl ? WORD_RESET :
                       (take_write && hit_pos) ? pwdata[WORD_W-1:0] : ctl_pos_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      preset_r <= WORD_RESET;
      tmr_word0_r <= WORD_RESET;
      tmr_acc_r <= WORD_RESET;
      ctl_word0_r <= WORD_RESET;
      ctl_pos_r <= WORD_RESET;
    end
    else if (ce)
    begin
      preset_r <= preset_nxt;
      tmr_word0_r <= tmr_word0_nxt;
      tmr_acc_r <= tmr_acc_nxt;
      ctl_word0_r <= ctl_word0_nxt;
      ctl_pos_r <= ctl_pos_nxt;
    end
  end

  // ****************************************
  // Counter element
  // ****************************************
  counter_core u_core
  (
    .pclk (pclk),
    .presetn (presetn),
    .ce (ce),
    .link (link.core)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_out_r <= 1'b0;
    else if (ce)
      done_out_r <= link.word0[BIT_DONE];
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign done_out = done_out_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_access_wait;
    ce && psel && penable && !pready_r && st_r == ap_idle;
  endsequence
  sequence s_read_done;
    psel && penable && pready_r && !pwrite;
  endsequence

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_access_wait |=> pready_r ##1 !pready_r)
    else $error("Answer not after one wait cycle");
  a_apb_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    s_access_wait ##0 !mapped |=> pslverr_r && pready_r)
    else $error("Unmapped access not refused");
  a_word_map_acc: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_done ##0 hit_acc |-> prdata_r == {16'h0000, link.acc})
    else $error("Count word read wrong");
  a_word_map_status: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_done ##0 hit_ctr0 |-> prdata_r == {16'h0000, link.word0})
    else $error("Status word read wrong");
  a_timer_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ce && clr_tmr |=> tmr_acc_r == WORD_RESET && (tmr_word0_r & TMR_CLEAR_MASK) == WORD_RESET)
    else $error("Timer element not cleared");
  a_control_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ce && clr_ctl |=> ctl_pos_r == WORD_RESET && (ctl_word0_r & CTL_CLEAR_MASK) == WORD_RESET)
    else $error("Control element not cleared");
  a_clear_false_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    ce && scan_r && !cmd_r[BIT_SCAN_CLR] |=> $stable(tmr_acc_r) && $stable(ctl_pos_r)
      && $stable(tmr_word0_r) && $stable(ctl_word0_r))
    else $error("Element changed without a clear");
  a_scan_follows_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && take_write && hit_scan |=> scan_r ##1 !scan_r)
    else $error("Scan pulse missing");
  a_done_pin: assert property (@(posedge pclk) disable iff (!presetn)
    ce ##1 ce |-> done_out_r == $past(link.word0[BIT_DONE]))
    else $error("Done pin lags wrong");

  // ****************************************
  // Bus, scan and element checks
  // ****************************************
  sequence s_scan_write;
    ce && take_write && hit_scan;
  endsequence
  sequence s_clear_scan;
    ce && scan_r && cmd_r[BIT_SCAN_CLR];
  endsequence

  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_r |-> pready_r)
    else $error("Error flag without ready");
  a_rdata_idle_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !pready_r |-> prdata_r == '0)
    else $error("Read data outside an answer");
  a_ready_needs_access: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !(psel && penable) |=> !pready_r)
    else $error("Ready without an access");
  a_bus_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(pready_r) && $stable(prdata_r) && $stable(pslverr_r) && $stable(st_r))
    else $error("Bus moved while frozen");

  a_cmd_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    s_scan_write |=> cmd_r == $past(pwdata[CMD_W-1:0]))
    else $error("Scan command not stored");
  a_scan_only_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !(take_write && hit_scan) |=> !scan_r)
    else $error("Scan without a command write");
  a_scan_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    ce && scan_r |=> scan_cnt_r == $past(scan_cnt_r) + 16'h0001)
    else $error("Scan count did not step");
  a_preset_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    ce && take_write && hit_preset |=> preset_r == $past(pwdata[WORD_W-1:0]))
    else $error("Preset write lost");
  a_tacc_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    ce && take_write && hit_tacc |=> tmr_acc_r == $past(pwdata[WORD_W-1:0]))
    else $error("Timer count write lost");
  a_pos_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    ce && take_write && hit_pos |=> ctl_pos_r == $past(pwdata[WORD_W-1:0]))
    else $error("Position write lost");

  a_clear_to_counter: assert property (@(posedge pclk) disable iff (!presetn)
    s_clear_scan ##0 target == TGT_COUNTER |=> link.acc == WORD_RESET)
    else $error("Counter clear not applied");
  a_clear_none_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    s_clear_scan ##0 target == 2'h3 |=> $stable(tmr_acc_r) && $stable(ctl_pos_r)
      && $stable(tmr_word0_r) && $stable(ctl_word0_r))
    else $error("Clear without target changed an element");
  a_timer_spare_bits: assert property (@(posedge pclk) disable iff (!presetn)
    ce && clr_tmr |=> (tmr_word0_r & ~TMR_CLEAR_MASK) == ($past(tmr_word0_r) & ~TMR_CLEAR_MASK))
    else $error("Timer clear touched other bits");
  a_control_spare_bits: assert property (@(posedge pclk) disable iff (!presetn)
    ce && clr_ctl |=> (ctl_word0_r & ~CTL_CLEAR_MASK) == ($past(ctl_word0_r) & ~CTL_CLEAR_MASK))
    else $error("Control clear touched other bits");
  a_timer_clear_only: assert property (@(posedge pclk) disable iff (!presetn)
    ce && clr_tmr |=> $stable(ctl_pos_r) && $stable(ctl_word0_r))
    else $error("Timer clear reached control element");
endmodule : retentive_up_down_counter
`default_nettype wire

/* File: shared/ctr_pkg.sv */
`default_nettype none
package ctr_pkg;
  // ****************************************
  // Bus and word widths
  // ****************************************
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam int CMD_W = 6;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTR_WORD0 = 8'h00;
  localparam logic [7:0] OFF_CTR_PRESET = 8'h04;
  localparam logic [7:0] OFF_CTR_ACC = 8'h08;
  localparam logic [7:0] OFF_SCAN_CMD = 8'h0c;
  localparam logic [7:0] OFF_TMR_WORD0 = 8'h10;
  localparam logic [7:0] OFF_TMR_ACC = 8'h14;
  localparam logic [7:0] OFF_CTL_WORD0 = 8'h18;
  localparam logic [7:0] OFF_CTL_POS = 8'h1c;
  localparam logic [7:0] OFF_SCAN_CNT = 8'h20;
  // ****************************************
  // Counter word 0 fields
  // ****************************************
  localparam int BIT_UP_EN = 15;
  localparam int BIT_DN_EN = 14;
  localparam int BIT_DONE = 13;
  localparam int BIT_WRAP_HI = 12;
  localparam int BIT_WRAP_LO = 11;
  // ****************************************
  // Scan command fields and targets
  // ****************************************
  localparam int BIT_SCAN_UP = 0;
  localparam int BIT_SCAN_DN = 1;
  localparam int BIT_SCAN_CLR = 2;
  localparam int TGT_LSB = 4;
  localparam logic [1:0] TGT_COUNTER = 2'h0;
  localparam logic [1:0] TGT_TIMER = 2'h1;
  localparam logic [1:0] TGT_CONTROL = 2'h2;
  // ****************************************
  // Values and clear masks
  // ****************************************
  localparam logic [15:0] ACC_MAX = 16'h7fff;
  localparam logic [15:0] ACC_MIN = 16'h8000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] TMR_CLEAR_MASK = 16'he000;
  localparam logic [15:0] CTL_CLEAR_MASK = 16'hfc00;
endpackage : ctr_pkg
`default_nettype wire

/* File: shared/counter_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface counter_link_if;
  import ctr_pkg::*;
  logic scan;
  logic up_rung;
  logic dn_rung;
  logic clr;
  logic [WORD_W-1:0] preset;
  logic [WORD_W-1:0] acc;
  logic [WORD_W-1:0] word0;
  modport ctrl (output scan, up_rung, dn_rung, clr, preset, input acc, word0);
  modport core (input scan, up_rung, dn_rung, clr, preset, output acc, word0);
endinterface : counter_link_if
`default_nettype wire

/* File: logic/counter_core.sv */
`timescale 1ns/100ps
`default_nettype none
module counter_core
(
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Scan side
  counter_link_if.core link
);
  import ctr_pkg::*;

  // ****************************************
  // Counting step
  // ****************************************
  function automatic logic [WORD_W:0] step(input logic [WORD_W-1:0] v, input logic up);
    logic [WORD_W-1:0] r;
    r = up ? v + 16'h0001 : v - 16'h0001;
    step = {(up ? (v == ACC_MAX) : (v == ACC_MIN)), r};
  endfunction : step

  logic [WORD_W-1:0] acc_r;
  logic ov_r, un_r, done_r, cu_r, cd_r;
  logic up_edge, dn_edge;
  logic [WORD_W:0] after_up, after_dn;
  logic [WORD_W-1:0] acc_nxt;

  assign up_edge = link.up_rung && !cu_r;
  assign dn_edge = link.dn_rung && !cd_r;
  assign after_up = up_edge ? step(acc_r, 1'b1) : {1'b0, acc_r};
  assign after_dn = dn_edge ? step(after_up[WORD_W-1:0], 1'b0) : {1'b0, after_up[WORD_W-1:0]};
  assign acc_nxt = link.clr ? WORD_RESET : after_dn[WORD_W-1:0];

  // ****************************************
  // Element state, changed only by a scan
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_r <= WORD_RESET;
      {ov_r, un_r, done_r, cu_r, cd_r} <= 5'h00;
    end
    else if (ce && link.scan)
    begin
      acc_r <= acc_nxt;
      ov_r <= !link.clr && (ov_r || after_up[WORD_W]);
      un_r <= !link.clr && (un_r || after_dn[WORD_W]);
      done_r <= !link.clr && ($signed(acc_nxt) >= $signed(link.preset));
      cu_r <= !link.clr && link.up_rung;
      cd_r <= !link.clr && link.dn_rung;
    end
  end

  assign link.acc = acc_r;
  assign link.word0 = {cu_r, cd_r, done_r, ov_r, un_r, 11'h000};

  // ****************************************
  // Checks
  // ****************************************
  sequence s_plain_scan;
    ce && link.scan && !link.clr;
  endsequence
  sequence s_up_only;
    s_plain_scan ##0 up_edge && !dn_edge;
  endsequence
  sequence s_dn_only;
    s_plain_scan ##0 dn_edge && !up_edge;
  endsequence

  a_up_count_inc: assert property (@(posedge pclk) disable iff (!presetn)
    s_up_only ##0 acc_r != ACC_MAX |=> acc_r == $past(acc_r) + 16'h0001)
    else $error("Up count did not add one");
  a_down_count_dec: assert property (@(posedge pclk) disable iff (!presetn)
    s_dn_only ##0 acc_r != ACC_MIN |=> acc_r == $past(acc_r) - 16'h0001)
    else $error("Down count did not subtract one");
  a_wrap_high_set: assert property (@(posedge pclk) disable iff (!presetn)
    s_up_only ##0 acc_r == ACC_MAX |=> acc_r == ACC_MIN && ov_r)
    else $error("High wrap wrong");
  a_wrap_low_set: assert property (@(posedge pclk) disable iff (!presetn)
    s_dn_only ##0 acc_r == ACC_MIN |=> acc_r == ACC_MAX && un_r)
    else $error("Low wrap wrong");
  a_done_tracks_preset: assert property (@(posedge pclk) disable iff (!presetn)
    s_plain_scan |=> done_r == ($signed(acc_r) >= $signed($past(link.preset))))
    else $error("Done flag disagrees with preset");
  a_enable_flags: assert property (@(posedge pclk) disable iff (!presetn)
    s_plain_scan |=> cu_r == $past(link.up_rung) && cd_r == $past(link.dn_rung))
    else $error("Enable flags do not follow rungs");
  a_state_retained: assert property (@(posedge pclk) disable iff (!presetn)
    !(ce && link.scan) |=> $stable(link.word0) && $stable(acc_r))
    else $error("State changed without a scan");
  a_wrap_flags_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (ov_r || un_r) ##0 !(ce && link.scan && link.clr) |=> ov_r >= $past(ov_r) && un_r >= $past(un_r))
    else $error("Wrap flag lost without a clear");
  a_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
    ce && link.scan && link.clr |=> acc_r == WORD_RESET && link.word0 == WORD_RESET)
    else $error("Clear left state behind");
  a_count_past_preset: assert property (@(posedge pclk) disable iff (!presetn)
    s_up_only ##0 done_r && acc_r != ACC_MAX && $signed(acc_r) >= $signed(link.preset)
      |=> done_r && acc_r == $past(acc_r) + 16'h0001)
    else $error("Counting stopped at preset");
endmodule : counter_core
`default_nettype wire

/* File: dv/field_rung_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Field input: level held a whole number of scans
// ****************************************
module field_rung_model
#(
  parameter int HOLD_SCANS = 2
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // One pulse per scan
  input wire logic step,
  // Field level
  output logic level
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      level <= 1'b0;
    end
    else if (step)
    begin
      if (cnt == HOLD_SCANS - 1)
      begin
        cnt <= 0;
        level <= ~level;
      end
      else
      begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : field_rung_model
`default_nettype wire

/* File: dv/retentive_up_down_counter_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module retentive_up_down_counter_tb;
  import ctr_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic done_out;
  logic step = 1'b0;
  logic field_lvl;
  int error_cnt = 0;
  int check_count = 0;
  int scan_n = 0;
  always #5 pclk = ~pclk;
  retentive_up_down_counter dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .done_out(done_out));
  field_rung_model model_u (.pclk(pclk), .presetn(presetn), .step(step), .level(field_lvl));
  // ****************************************
  // Report and compare
  // ****************************************
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ****************************************
  // APB master
  // ****************************************
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'b1, a, {16'h0000, d}, r, e);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] exp);
    logic [DATA_W-1:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, {16'h0000, exp});
  endtask : rd
  task automatic scan(input logic [CMD_W-1:0] c);
    wr(OFF_SCAN_CMD, {10'h000, c});
    scan_n++;
  endtask : scan
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [DATA_W-1:0] r;
    logic e;
    for (int i = 0; i < 9; i++)
    begin
      rd(8'(4 * i), 16'h0000);
    end
    apb(1'b0, 8'h40, 32'h0000_0000, r, e);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    wr(OFF_CTR_ACC, 16'h0005);
    rd(OFF_CTR_ACC, 16'h0000);
    wr(OFF_CTR_PRESET, 16'h8000);
    rd(OFF_CTR_PRESET, 16'h8000);
  endtask : t_regs
  task automatic t_up();
    wr(OFF_CTR_PRESET, 16'h0002);
    scan(6'h01);
    rd(OFF_CTR_ACC, 16'h0001);
    rd(OFF_CTR_WORD0, 16'h8000);
    scan(6'h01);
    rd(OFF_CTR_ACC, 16'h0001);
    scan(6'h00);
    rd(OFF_CTR_WORD0, 16'h0000);
    scan(6'h01);
    rd(OFF_CTR_WORD0, 16'ha000);
    chk({31'h0000_0000, done_out}, 32'h0000_0001);
    scan(6'h00);
    rd(OFF_CTR_ACC, 16'h0002);
    rd(OFF_CTR_WORD0, 16'h2000);
    scan(6'h01);
    rd(OFF_CTR_ACC, 16'h0003);
  endtask : t_up
  task automatic t_down();
    scan(6'h02);
    rd(OFF_CTR_ACC, 16'h0002);
    rd(OFF_CTR_WORD0, 16'h6000);
    scan(6'h00);
    rd(OFF_CTR_WORD0, 16'h2000);
    scan(6'h02);
    rd(OFF_CTR_ACC, 16'h0001);
    rd(OFF_CTR_WORD0, 16'h4000);
    chk({31'h0000_0000, done_out}, 32'h0000_0000);
  endtask : t_down
  task automatic t_clear();
    scan(6'h00);
    rd(OFF_CTR_ACC, 16'h0001);
    scan(6'h05);
    rd(OFF_CTR_ACC, 16'h0000);
    rd(OFF_CTR_WORD0, 16'h0000);
    scan(6'h01);
    rd(OFF_CTR_ACC, 16'h0001);
    rd(OFF_CTR_WORD0, 16'h8000);
    scan(6'h04);
    rd(OFF_CTR_WORD0, 16'h0000);
    scan(6'h03);
    rd(OFF_CTR_ACC, 16'h0000);
    rd(OFF_CTR_WORD0, 16'hc000);
  endtask : t_clear
  task automatic t_signed();
    wr(OFF_CTR_PRESET, 16'hfffe);
    scan(6'h00);
    rd(OFF_CTR_WORD0, 16'h2000);
    scan(6'h02);
    scan(6'h00);
    scan(6'h02);
    rd(OFF_CTR_ACC, 16'hfffe);
    rd(OFF_CTR_WORD0, 16'h6000);
    scan(6'h00);
    scan(6'h02);
    rd(OFF_CTR_ACC, 16'hfffd);
    rd(OFF_CTR_WORD0, 16'h4000);
    scan(6'h04);
  endtask : t_signed
  task automatic t_field();
    logic prev;
    logic [WORD_W-1:0] exp;
    prev = 1'b0;
    exp = 16'h0000;
    for (int i = 0; i < 12; i++)
    begin
      if (field_lvl && !prev)
        exp++;
      prev = field_lvl;
      scan({5'h00, field_lvl});
      step <= 1'b1;
      @(posedge pclk);
      step <= 1'b0;
    end
    rd(OFF_CTR_ACC, exp);
    scan(6'h04);
  endtask : t_field
  task automatic t_other();
    scan(6'h01);
    wr(OFF_TMR_WORD0, 16'hffff);
    wr(OFF_TMR_ACC, 16'h1234);
    wr(OFF_CTL_WORD0, 16'hffff);
    wr(OFF_CTL_POS, 16'h00ab);
    scan(6'h10);
    rd(OFF_TMR_ACC, 16'h1234);
    scan(6'h34);
    rd(OFF_TMR_WORD0, 16'hffff);
    scan(6'h14);
    rd(OFF_TMR_WORD0, 16'h1fff);
    rd(OFF_TMR_ACC, 16'h0000);
    rd(OFF_CTR_ACC, 16'h0001);
    rd(OFF_CTL_POS, 16'h00ab);
    scan(6'h24);
    rd(OFF_CTL_WORD0, 16'h03ff);
    rd(OFF_CTL_POS, 16'h0000);
  endtask : t_other
  task automatic t_freeze();
    logic [DATA_W-1:0] r;
    logic e;
    ce <= 1'b0;
    fork
      apb(1'b1, OFF_SCAN_CMD, 32'h0000_0001, r, e);
      begin
        repeat (6) @(posedge pclk);
        chk({31'h0000_0000, pready}, 32'h0000_0000);
        ce <= 1'b1;
      end
    join
    scan_n++;
    rd(OFF_CTR_ACC, 16'h0002);
    rd(OFF_CTR_WORD0, 16'ha000);
  endtask : t_freeze
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_up();
    t_down();
    t_clear();
    t_signed();
    t_field();
    t_other();
    t_freeze();
    rd(OFF_SCAN_CNT, 16'(scan_n));
    close_out();
  end
endmodule : retentive_up_down_counter_tb
`default_nettype wire
